/* bench/mio_board.sv */
// Board model: resolves each pad from drive, pulls or nothing.
// Assumes pad controls from mio_port_top on the same clock.
`timescale 1ns/10ps
module mio_board
  import mio_pkg::*;
(
  input wire logic clk_in,
  input wire logic [NPORT-1:0][PW-1:0] out_in,
  input wire logic [NPORT-1:0][PW-1:0] oe_in,
  input wire logic [NPORT-1:0][PW-1:0] pu_in,
  input wire logic [NPORT-1:0][PW-1:0] pd_in,
  output logic [NPORT-1:0][PW-1:0] pin_out
);
  logic [NPORT-1:0][PW-1:0] float_r = '0;
  // Open pads wander every cycle
  always @(posedge clk_in) float_r <= ~float_r;
  assign pin_out = (oe_in & out_in) | (~oe_in & pu_in) | (~oe_in & ~pu_in & ~pd_in & float_r);
endmodule : mio_board

/* bench/mio_port_sva.sv */
// Checker for the I/O port top: pad controls, fixed pins, converter.
// Assumes binding to mio_port_top; sees only its ports.
`timescale 1ns/10ps
module mio_port_sva
  import mio_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [NPORT-1:0][PW-1:0] pin_oe_out,
  input wire logic [NPORT-1:0][PW-1:0] pull_up_out,
  input wire logic [NPORT-1:0][PW-1:0] pull_dn_out,
  input wire logic cpu_active_in,
  input wire logic fe_ctrl_a_in,
  input wire logic converter_ctrl_out,
  input wire logic front_end_ctrl_a_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_cpu_rise;
    $rose(cpu_active_in);
  endsequence
  sequence s_cpu_fall;
    $fell(cpu_active_in);
  endsequence
  a_reset_pull_up: assert property ($fell(rst_in) |-> pull_up_out == PIN_MASK &&
    pin_oe_out == '0 && pull_dn_out == '0) else $error("pads not reset to pulled inputs");
  a_pull_exclusive: assert property ((pull_up_out & pull_dn_out) == '0)
    else $error("pull-up and pull-down both on");
  a_output_no_pull: assert property (((pull_up_out | pull_dn_out) & pin_oe_out) == '0)
    else $error("driven pin has pull");
  a_whole_port: assert property (!(|pull_up_out[0] && |pull_dn_out[0]) &&
    !(|pull_up_out[1] && |pull_dn_out[1]) && !(|pull_up_out[2] && |pull_dn_out[2]))
    else $error("mixed pull direction in a port");
  a_reserved_quiet: assert property ((pin_oe_out[1][1:0] | pull_up_out[1][1:0] |
    pull_dn_out[1][1:0]) == 2'h0) else $error("reserved pin touched");
  a_conv_fixed: assert property ({pin_oe_out[1][7], pull_up_out[1][7],
    pull_dn_out[1][7]} == 3'h0) else $error("converter pin altered");
  a_conv_on: assert property (s_cpu_rise |=> converter_ctrl_out)
    else $error("converter not on");
  a_conv_off: assert property (s_cpu_fall |=> !converter_ctrl_out)
    else $error("converter not bypassed");
  a_fe_follow: assert property (!$past(rst_in) |-> front_end_ctrl_a_out ==
    $past(fe_ctrl_a_in)) else $error("front-end output not following");
endmodule : mio_port_sva
bind mio_port_top mio_port_sva i_sva (.clk_in, .rst_in, .pin_oe_out, .pull_up_out,
  .pull_dn_out, .cpu_active_in, .fe_ctrl_a_in, .converter_ctrl_out, .front_end_ctrl_a_out);

/* bench/module_io_port_config_test.sv */
// Testbench for the I/O port top over AHB-Lite.
// Assumes zero-wait slave and the board model on the pads.
`timescale 1ns/10ps
module module_io_port_config_test
  import mio_pkg::*;
;
  logic clk_in = 0, rst_in = 1, hsel_in = 0, hwrite_in = 0;
  logic cpu_active_in = 0, fe_a = 0, fe_b = 0, hready, hresp, conv, fea, feb;
  logic [31:0] haddr_in = '0, hwdata_in = '0, hrdata;
  logic [1:0] htrans_in = '0;
  logic [2:0] hsize_in = HSIZE_WORD;
  logic [NPORT-1:0][PW-1:0] pin, po = '0, poe = '0, pout, poeo, pu, pd, pin_sy;
  int bad_count = 0, n_tests = 0;
  mio_port_top i_dut (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .pin_in(pin), .periph_o_in(po), .periph_oe_in(poe), .periph_in_out(pin_sy),
    .pin_out_out(pout), .pin_oe_out(poeo), .pull_up_out(pu), .pull_dn_out(pd), .cpu_active_in,
    .fe_ctrl_a_in(fe_a), .fe_ctrl_b_in(fe_b), .front_end_ctrl_a_out(fea),
    .front_end_ctrl_b_out(feb), .converter_ctrl_out(conv));
  mio_board i_board (.clk_in, .out_in(pout), .oe_in(poeo), .pu_in(pu), .pd_in(pd), .pin_out(pin));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= HTRANS_NONSEQ;
    hwrite_in <= wr;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string w, input logic [31:0] a, exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(w, q, exp);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    #50000;
    bad_count++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check("pull_up", 32'(pu), 32'(PIN_MASK));
    check("oe", 32'(poeo), 32'h0);
    rd("in_p0", 32'h10, 32'hff);
    $display("test reset done");
    wr(32'h04, 32'h0f);
    wr(32'h00, 32'ha5);
    settle;
    check("oe", 32'(poeo), 32'h0f);
    check("out", 32'(pout), 32'ha5);
    check("pull_up", 32'(pu), 32'h077cf0);
    rd("in_p0", 32'h10, 32'hf5);
    check("periph_in", 32'(pin_sy[0]), 32'hf5);
    check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    $display("test direction done");
    wr(32'h60, 32'h1);
    settle;
    check("pull_up", 32'(pu), 32'h077c00);
    check("pull_dn", 32'(pd), 32'hf0);
    rd("in_p0", 32'h10, 32'h05);
    rd("pull", 32'h60, 32'h1);
    wr(32'h0c, 32'h30);
    settle;
    check("pull_dn", 32'(pd), 32'hc0);
    $display("test pulls done");
    @(posedge clk_in);
    po <= 24'h010000;
    poe <= 24'h010000;
    wr(32'h48, 32'h07);
    settle;
    check("pull_up", 32'(pu), 32'h007c00);
    check("oe", 32'(poeo), 32'h01000f);
    $display("test peripheral done");
    wr(32'h24, 32'hff);
    wr(32'h20, 32'hff);
    settle;
    check("oe", 32'(poeo), 32'h017c0f);
    check("out", 32'(pout), 32'h017ca5);
    rd("dir_p1", 32'h24, 32'h7c);
    rd("unmapped", 32'h1c, 32'h0);
    wr(32'h14, 32'h0a);
    wr(32'h18, 32'h21);
    rd("dout_p0", 32'h00, 32'h8e);
    rd("set_p0", 32'h14, 32'h0);
    wr(32'h80, 32'hff);
    rd("bad_addr", 32'h80, 32'h0);
    @(posedge clk_in);
    hsize_in <= 3'h0;
    wr(32'h00, 32'hff);
    hsize_in <= HSIZE_WORD;
    rd("dout_p0", 32'h00, 32'h8e);
    settle;
    check("out_p0", 32'(pout[0]), 32'h8e);
    $display("test reserved done");
    @(posedge clk_in);
    cpu_active_in <= 1'b1;
    fe_a <= 1'b1;
    settle;
    check("conv", {31'h0, conv}, 32'h1);
    check("fe_a", {31'h0, fea}, 32'h1);
    rd("stat", 32'h64, 32'h3);
    @(posedge clk_in);
    cpu_active_in <= 1'b0;
    fe_a <= 1'b0;
    fe_b <= 1'b1;
    settle;
    check("conv", {31'h0, conv}, 32'h0);
    check("fe_b", {31'h0, feb}, 32'h1);
    rd("stat", 32'h64, 32'h4);
    $display("test converter done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check("pull_up", 32'(pu), 32'(PIN_MASK));
    check("pull_dn", 32'(pd), 32'h0);
    check("oe", 32'(poeo), 32'h0);
    @(posedge clk_in);
    rst_in <= 1'b0;
    settle;
    check("pull_up", 32'(pu), 32'(PIN_MASK));
    rd("pull", 32'h60, 32'h0);
    rd("dir_p0", 32'h04, 32'h0);
    $display("test reset again done");
    close_out;
  end
endmodule : module_io_port_config_test

/* logic/mio_pad_ctl.sv */
// Combinational pad control for one 8-pin port.
// Assumes registered configuration at its inputs; the caller registers the result.
`timescale 1ns/10ps
module mio_pad_ctl
  import mio_pkg::*;
(
  input wire logic [PW-1:0] mask_in,
  input wire logic [PW-1:0] dout_in,
  input wire logic [PW-1:0] dir_in,
  input wire logic [PW-1:0] sel_in,
  input wire logic [PW-1:0] tris_in,
  input wire logic pull_dn_in,
  input wire logic [PW-1:0] periph_o_in,
  input wire logic [PW-1:0] periph_oe_in,
  output logic [PW-1:0] o_out,
  output logic [PW-1:0] oe_out,
  output logic [PW-1:0] pu_out,
  output logic [PW-1:0] pd_out
);
  logic [PW-1:0] pull_en;

  assign pull_en = mask_in & ~sel_in & ~dir_in & ~tris_in;
  assign pu_out = pull_dn_in ? '0 : pull_en;
  assign pd_out = pull_dn_in ? pull_en : '0;
  assign oe_out = mask_in & ((sel_in & periph_oe_in) | (~sel_in & dir_in));
  assign o_out = mask_in & ((sel_in & periph_o_in) | (~sel_in & dout_in));
endmodule : mio_pad_ctl

/* logic/mio_pkg.sv */
// Constants for the I/O port block: register map, field layout and reset values.
// Shared by the port top, its pad-control leaf and the bench files.
package mio_pkg;

  localparam int NPORT = 3;
  localparam int PW = 8;

  // Pins that exist as general-purpose pins, per port (port 2 first)
  localparam logic [NPORT-1:0][PW-1:0] PIN_MASK = {8'h07, 8'h7c, 8'hff};

  // Fixed-function port-1 bit positions
  localparam int FE_A_BIT = 0;
  localparam int FE_B_BIT = 1;
  localparam int CONV_BIT = 7;

  // Register offsets inside one port block
  localparam logic [4:0] OFS_DOUT = 5'h00;
  localparam logic [4:0] OFS_DIR = 5'h04;
  localparam logic [4:0] OFS_SEL = 5'h08;
  localparam logic [4:0] OFS_TRIS = 5'h0c;
  localparam logic [4:0] OFS_IN = 5'h10;
  localparam logic [4:0] OFS_SET = 5'h14;
  localparam logic [4:0] OFS_CLR = 5'h18;
  // Global block sits where a fourth port would be
  localparam logic [1:0] GLOBAL_IDX = 2'h3;
  localparam logic [4:0] OFS_PULL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam int ADDR_W = 7;

  // Status bit positions
  localparam int STAT_CONV = 0;
  localparam int STAT_FE_A = 1;
  localparam int STAT_FE_B = 2;

  // Reset values
  localparam logic [PW-1:0] RST_DOUT = 8'h00;
  localparam logic [PW-1:0] RST_DIR = 8'h00;
  localparam logic [PW-1:0] RST_SEL = 8'h00;
  localparam logic [PW-1:0] RST_TRIS = 8'h00;
  localparam logic [NPORT-1:0] RST_PULL_DN = 3'h0;
  localparam logic RST_CONV = 1'b0;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : mio_pkg

/* logic/mio_port_top.sv */
// General-purpose I/O ports with AHB-Lite register access and fixed front-end pins.
// Assumes a single AHB-Lite master, pads outside resolving out/oe/pull controls.
`timescale 1ns/10ps
module mio_port_top
  import mio_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [NPORT-1:0][PW-1:0] pin_in,
  input wire logic [NPORT-1:0][PW-1:0] periph_o_in,
  input wire logic [NPORT-1:0][PW-1:0] periph_oe_in,
  output logic [NPORT-1:0][PW-1:0] periph_in_out,
  output logic [NPORT-1:0][PW-1:0] pin_out_out,
  output logic [NPORT-1:0][PW-1:0] pin_oe_out,
  output logic [NPORT-1:0][PW-1:0] pull_up_out,
  output logic [NPORT-1:0][PW-1:0] pull_dn_out,
  input wire logic cpu_active_in,
  input wire logic fe_ctrl_a_in,
  input wire logic fe_ctrl_b_in,
  output logic front_end_ctrl_a_out,
  output logic front_end_ctrl_b_out,
  output logic converter_ctrl_out
);

  typedef struct packed {
    logic [NPORT-1:0][PW-1:0] dout;
    logic [NPORT-1:0][PW-1:0] dir;
    logic [NPORT-1:0][PW-1:0] sel;
    logic [NPORT-1:0][PW-1:0] tris;
    logic [NPORT-1:0] pull_dn;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
    logic [NPORT-1:0][PW-1:0] pad_o;
    logic [NPORT-1:0][PW-1:0] pad_oe;
    logic [NPORT-1:0][PW-1:0] pad_pu;
    logic [NPORT-1:0][PW-1:0] pad_pd;
    logic conv;
    logic fe_a;
    logic fe_b;
  } mio_st_t;

  mio_st_t st_r;
  mio_st_t st_nxt;

  logic [NPORT-1:0][PW-1:0] pin_sync;
  logic [NPORT-1:0][PW-1:0] pc_o;
  logic [NPORT-1:0][PW-1:0] pc_oe;
  logic [NPORT-1:0][PW-1:0] pc_pu;
  logic [NPORT-1:0][PW-1:0] pc_pd;

  mio_sync #(
    .W(NPORT * PW)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(pin_in),
    .q_out(pin_sync)
  );

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      mio_pad_ctl u_pad (
        .mask_in(PIN_MASK[gp]),
        .dout_in(st_r.dout[gp]),
        .dir_in(st_r.dir[gp]),
        .sel_in(st_r.sel[gp]),
        .tris_in(st_r.tris[gp]),
        .pull_dn_in(st_r.pull_dn[gp]),
        .periph_o_in(periph_o_in[gp]),
        .periph_oe_in(periph_oe_in[gp]),
        .o_out(pc_o[gp]),
        .oe_out(pc_oe[gp]),
        .pu_out(pc_pu[gp]),
        .pd_out(pc_pd[gp])
      );
    end
  endgenerate

  // Register read view, taken from the state after any pending write
  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input mio_st_t v,
                                          input logic [NPORT-1:0][PW-1:0] pins);
    logic [1:0] pidx;
    logic [4:0] roff;
    logic [31:0] w;
    pidx = a[6:5];
    roff = a[4:0];
    w = '0;
    if (pidx == GLOBAL_IDX) begin
      if (roff == OFS_PULL) begin
        w[NPORT-1:0] = v.pull_dn;
      end else if (roff == OFS_STAT) begin
        w[STAT_CONV] = v.conv;
        w[STAT_FE_A] = v.fe_a;
        w[STAT_FE_B] = v.fe_b;
      end
    end else begin
      case (roff)
        OFS_DOUT: w[PW-1:0] = v.dout[pidx];
        OFS_DIR: w[PW-1:0] = v.dir[pidx];
        OFS_SEL: w[PW-1:0] = v.sel[pidx];
        OFS_TRIS: w[PW-1:0] = v.tris[pidx];
        OFS_IN: w[PW-1:0] = pins[pidx] & PIN_MASK[pidx];
        default: w = '0;
      endcase
    end
    return w;
  endfunction : rd_word

  logic acc;
  logic addr_ok;
  logic [1:0] wp;
  logic [4:0] wo;
  logic [PW-1:0] wb;
  logic [PW-1:0] wm;

  always_comb begin
    st_nxt = st_r;
    acc = hsel_in & hready_in & (htrans_in == HTRANS_NONSEQ);
    addr_ok = (haddr_in[31:ADDR_W] == '0) & (haddr_in[1:0] == 2'h0);
    wp = st_r.wr_addr[6:5];
    wo = st_r.wr_addr[4:0];
    wb = hwdata_in[PW-1:0];
    wm = '0;
    // Data phase of an accepted write
    if (st_r.wr_pend) begin
      if (wp == GLOBAL_IDX) begin
        if (wo == OFS_PULL) begin
          st_nxt.pull_dn = hwdata_in[NPORT-1:0];
        end
      end else begin
        wm = PIN_MASK[wp];
        case (wo)
          OFS_DOUT: st_nxt.dout[wp] = wb & wm;
          OFS_SET: st_nxt.dout[wp] = (st_r.dout[wp] | wb) & wm;
          OFS_CLR: st_nxt.dout[wp] = st_r.dout[wp] & ~wb & wm;
          OFS_DIR: st_nxt.dir[wp] = wb & wm;
          OFS_SEL: st_nxt.sel[wp] = wb & wm;
          OFS_TRIS: st_nxt.tris[wp] = wb & wm;
          default: st_nxt.wr_pend = 1'b0;
        endcase
      end
    end
    st_nxt.wr_pend = 1'b0;
    if (acc && addr_ok && hwrite_in && (hsize_in == HSIZE_WORD)) begin
      st_nxt.wr_pend = 1'b1;
      st_nxt.wr_addr = haddr_in[ADDR_W-1:0];
    end
    if (acc && !hwrite_in) begin
      st_nxt.rdata = addr_ok ? rd_word(haddr_in[ADDR_W-1:0], st_nxt, pin_sync) : '0;
    end
    st_nxt.readyout = 1'b1;
    st_nxt.resp = HRESP_OKAY;
    st_nxt.pad_o = pc_o;
    st_nxt.pad_oe = pc_oe;
    st_nxt.pad_pu = pc_pu;
    st_nxt.pad_pd = pc_pd;
    st_nxt.conv = cpu_active_in;
    st_nxt.fe_a = fe_ctrl_a_in;
    st_nxt.fe_b = fe_ctrl_b_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r.dout <= {NPORT{RST_DOUT}};
      st_r.dir <= {NPORT{RST_DIR}};
      st_r.sel <= {NPORT{RST_SEL}};
      st_r.tris <= {NPORT{RST_TRIS}};
      st_r.pull_dn <= RST_PULL_DN;
      st_r.wr_pend <= 1'b0;
      st_r.wr_addr <= '0;
      st_r.rdata <= '0;
      st_r.readyout <= 1'b1;
      st_r.resp <= HRESP_OKAY;
      st_r.pad_o <= '0;
      st_r.pad_oe <= '0;
      st_r.pad_pu <= PIN_MASK;
      st_r.pad_pd <= '0;
      st_r.conv <= RST_CONV;
      st_r.fe_a <= 1'b0;
      st_r.fe_b <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata_out = st_r.rdata;
  assign hreadyout_out = st_r.readyout;
  assign hresp_out = st_r.resp;
  assign periph_in_out = pin_sync;
  assign pin_out_out = st_r.pad_o;
  assign pin_oe_out = st_r.pad_oe;
  assign pull_up_out = st_r.pad_pu;
  assign pull_dn_out = st_r.pad_pd;
  assign converter_ctrl_out = st_r.conv;
  assign front_end_ctrl_a_out = st_r.fe_a;
  assign front_end_ctrl_b_out = st_r.fe_b;

endmodule : mio_port_top

/* logic/mio_sync.sv */
// Two-flop synchroniser for a vector of pad inputs.
// Assumes the inputs are asynchronous to clk_in.
`timescale 1ns/10ps
module mio_sync #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mio_sync_st_t;

  mio_sync_st_t st_r;
  mio_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.s2;
endmodule : mio_sync
